// ===== dv/oec_checker.sv
/*
  Port-level assertions for the oscillator enable control block.
  Assumes it is bound to oec_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none

module oec_checker
#(
    parameter int SETTLE_CYCLES = 10
)
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port.
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [15:0] reg_rdata,
    // Oscillator control and interrupt.
    input  wire logic        osc_enable,
    input  wire logic        dc_generator_enable,
    input  wire logic        osc_ready,
    input  wire logic        sub_main_clock_stuck_high,
    input  wire logic        irq
);
    localparam int SETTLE_LIM = SETTLE_CYCLES + 6;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    reset_state_a:
        assert property ($fell(rst) |-> !osc_enable && !osc_ready && dc_generator_enable
            && !sub_main_clock_stuck_high && !irq && reg_rdata == 16'h0000)
        else $error("outputs not at reset values after reset");
    stay_off_a:
        assert property (!osc_enable && !reg_write && !$past(reg_write) && !$past(reg_write, 2)
            && !$past(rst) && !$past(rst, 2) |=> !osc_enable)
        else $error("oscillator started without a request");
    ready_enabled_a:
        assert property (osc_ready |-> osc_enable)
        else $error("oscillator ready while disabled");
    main_start_a:
        assert property (reg_write && reg_addr == 4'h0 && !reg_wdata[7]
            |-> ##[1:3] (osc_enable && dc_generator_enable))
        else $error("main select of oscillator did not start it");
    settle_bound_a:
        assert property ($rose(osc_enable) |-> ##[1:SETTLE_LIM] (osc_ready || !osc_enable))
        else $error("oscillator did not become ready in time");
    stuck_off_a:
        assert property (sub_main_clock_stuck_high |-> !osc_enable || !$past(osc_enable))
        else $error("sub-main clock stuck while oscillator runs");
    fault_start_a:
        assert property (reg_write && reg_addr == 4'h1 && reg_wdata[1] |-> ##[1:3] osc_enable)
        else $error("fault flag did not start oscillator");
    gen_off_a:
        assert property (!dc_generator_enable |-> !osc_ready)
        else $error("dc generator off while oscillator ready");
    state_read_a:
        assert property (reg_read && reg_addr == 4'h4 |=> reg_rdata[3:0] == $past(
            {dc_generator_enable, sub_main_clock_stuck_high, osc_ready, osc_enable}))
        else $error("oscillator state read mismatch");
endmodule

bind oec_top oec_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) oec_checker_i
(
    .clock                     (clock),
    .rst                       (rst),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_write                 (reg_write),
    .reg_read                  (reg_read),
    .reg_rdata                 (reg_rdata),
    .osc_enable                (osc_enable),
    .dc_generator_enable       (dc_generator_enable),
    .osc_ready                 (osc_ready),
    .sub_main_clock_stuck_high (sub_main_clock_stuck_high),
    .irq                       (irq)
);

`default_nettype wire

// ===== dv/test_oec_top.sv
/*
  Self-checking testbench for the oscillator enable control block.
  Assumes the design's register map and a single 250 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none

module test_oec_top;
    localparam int SETTLE = 4;
    localparam int WAIT_N = SETTLE + 6;

    logic        clock;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [15:0] reg_rdata;
    logic        osc_enable;
    logic        dc_generator_enable;
    logic        osc_ready;
    logic        sub_main_clock_stuck_high;
    logic        irq;
    int          err_total;
    int          check_count;
    int          seed;
    logic        on;
    logic [15:0] d;
    logic [7:0]  plan [8];

    oec_top #(.SETTLE_CYCLES(SETTLE)) oec_top_i
    (
        .clock                     (clock),
        .rst                       (rst),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_write                 (reg_write),
        .reg_read                  (reg_read),
        .reg_rdata                 (reg_rdata),
        .osc_enable                (osc_enable),
        .dc_generator_enable       (dc_generator_enable),
        .osc_ready                 (osc_ready),
        .sub_main_clock_stuck_high (sub_main_clock_stuck_high),
        .irq                       (irq)
    );

    always #2 clock = ~clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
        @(posedge clock);
    endtask

    task automatic look(input int n, input logic [15:0] exp);
        repeat (n) @(posedge clock);
        #1;
        chk({11'h0, irq, dc_generator_enable, sub_main_clock_stuck_high, osc_ready, osc_enable},
            exp);
        @(posedge clock);
    endtask

    // Expected port state after a new clock source selection.
    function automatic logic [15:0] model(input logic [7:0] s);
        logic st;
        st = !s[3] && !on && s[7];
        on = !s[7] || (!s[3] && on);
        return {11'h0, 1'b0, 1'b1, st, on, on};
    endfunction

    task automatic step(input logic [7:0] s);
        wr(4'h0, {8'h00, s});
        look(WAIT_N, model(s));
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog sized well beyond the roughly 510 cycles the sequence needs.
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize;
    end

    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        err_total = 0;
        check_count = 0;
        seed = 32'h501402d4;
        on = 1'b0;
        plan = '{8'h88, 8'h80, 8'h00, 8'h80, 8'h48, 8'h88, 8'h80, 8'h40};
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        look(0, 16'h0008);
        for (int a = 0; a < 16; a++)
            if (a != 4 && a != 5)
                rdchk(4'(a), 16'h0000);
        on = 1'b1;
        look(0, 16'h000b);
        rdchk(4'h4, 16'h000b);
        foreach (plan[i])
            step(plan[i]);
        for (int i = 0; i < 16; i++)
        begin
            d = 16'($random(seed));
            step({(d[1:0] == 2'b11) ? 2'b10 : d[1:0], 2'b00, d[2], 3'b000});
        end
        step(8'h88);
        wr(4'h2, 16'h0040);
        look(2, 16'h0000);
        rdchk(4'h2, 16'h0040);
        step(8'h08);
        wr(4'h2, 16'h0000);
        step(8'h88);
        wr(4'h1, 16'h0002);
        look(WAIT_N, 16'h000b);
        rdchk(4'h1, 16'h0002);
        wr(4'h1, 16'h0000);
        look(WAIT_N, 16'h0008);
        wr(4'h7, 16'h0001);
        wr(4'h0, 16'h0080);
        look(WAIT_N, 16'h000b);
        wr(4'h0, 16'h0088);
        wr(4'h7, 16'h0000);
        look(WAIT_N, 16'h0008);
        rdchk(4'h5, 16'h0007);
        wr(4'h5, 16'h000f);
        wr(4'h6, 16'h0001);
        look(2, 16'h0008);
        wr(4'h0, 16'h0000);
        look(WAIT_N, 16'h001b);
        rdchk(4'h5, 16'h0001);
        wr(4'h6, 16'h0000);
        look(2, 16'h000b);
        rdchk(4'h6, 16'h0000);
        wr(4'h6, 16'h0001);
        look(2, 16'h001b);
        wr(4'h5, 16'h0001);
        look(2, 16'h000b);
        rdchk(4'h5, 16'h0000);
        wr(4'h9, 16'hffff);
        rdchk(4'h9, 16'h0000);
        summarize;
    end
endmodule

`default_nettype wire

// ===== logic/oec_irq_bank.sv
/*
  Interrupt bank: sticky event bits cleared by writing one, a mask, and one level output.
  Assumes event pulses and clear strobes are synchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none

module oec_irq_bank
#(
    parameter int N = 4
)
(
    // Clock and reset.
    input  wire logic         clock,
    input  wire logic         rst,
    // Events and software access.
    input  wire logic [N-1:0] event_pulse,
    input  wire logic         clear_write,
    input  wire logic         mask_write,
    input  wire logic [N-1:0] write_data,
    // State.
    output logic      [N-1:0] status,
    output logic      [N-1:0] mask,
    output logic              irq
);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            status <= '0;
        end
        else
        begin
            // A new event wins over a clear in the same cycle.
            status <= (status & ~(clear_write ? write_data : '0)) | event_pulse;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mask <= '0;
        end
        else if (mask_write)
        begin
            mask <= write_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(((status & ~(clear_write ? write_data : '0)) | event_pulse) & mask);
        end
    end

endmodule

`default_nettype wire

// ===== logic/oec_pkg.sv
/*
  Package for the oscillator enable control block: register offsets, field positions,
  reset values, clock source codes and timing counts.
  Assumes a single 250 MHz clock domain and a plain strobe register port.
*/
`default_nettype none

package oec_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_CLOCK_CONTROL_TWO = 4'h0;
    localparam logic [3:0] ADDR_INTERRUPT_FLAG    = 4'h1;
    localparam logic [3:0] ADDR_STATUS_REGISTER   = 4'h2;
    localparam logic [3:0] ADDR_RESET_VECTOR      = 4'h3;
    localparam logic [3:0] ADDR_OSC_STATE         = 4'h4;
    localparam logic [3:0] ADDR_EVENT_STATUS      = 4'h5;
    localparam logic [3:0] ADDR_EVENT_MASK        = 4'h6;
    localparam logic [3:0] ADDR_CONTROL           = 4'h7;

    // Field positions.
    localparam int MAIN_SEL_LSB       = 6;
    localparam int SUB_SEL_BIT        = 3;
    localparam int FAULT_FLAG_BIT     = 1;
    localparam int GEN_OFF_BIT        = 6;
    localparam int VECTOR_TRIGGER_BIT = 6;
    localparam int CTRL_FIX_SUB_BIT   = 0;

    // Main clock source codes; both low codes pick the oscillator.
    localparam logic [1:0] MAIN_SEL_OSC_A = 2'h0;
    localparam logic [1:0] MAIN_SEL_OSC_B = 2'h1;
    localparam logic [1:0] MAIN_SEL_XTAL  = 2'h2;

    // Reset values.
    localparam logic [7:0]  CLOCK_CONTROL_TWO_RESET = 8'h00;
    localparam logic [7:0]  INTERRUPT_FLAG_RESET    = 8'h00;
    localparam logic [15:0] STATUS_REGISTER_RESET   = 16'h0000;
    localparam logic [15:0] RESET_VECTOR_RESET      = 16'h0000;
    localparam logic [3:0]  EVENT_RESET             = 4'h0;
    localparam logic [7:0]  CONTROL_RESET           = 8'h00;

    // Event bits of the interrupt status register.
    localparam int EV_OSC_START   = 0;
    localparam int EV_OSC_STOP    = 1;
    localparam int EV_START_FAIL  = 2;
    localparam int EV_GEN_OFF_SET = 3;

    // Oscillator settle time before its clock counts as ready.
    localparam int CLOCK_MHZ      = 250;
    localparam int SETTLE_NS      = 40;
    localparam int SETTLE_CYCLES  = (SETTLE_NS * CLOCK_MHZ + 999) / 1000;

    typedef enum logic [1:0]
    {
        OEC_OFF,
        OEC_STARTING,
        OEC_RUNNING
    } oec_osc_state_e;

endpackage

`default_nettype wire

// ===== logic/oec_settle_timer.sv
/*
  Settle timer: counts a fixed number of cycles after start and then reports done.
  Assumes start is held for as long as the oscillator is wanted.
*/
`timescale 1ns/100ps
`default_nettype none

module oec_settle_timer
#(
    parameter int CYCLES = 10
)
(
    // Clock and reset.
    input  wire logic clock,
    input  wire logic rst,
    // Control.
    input  wire logic run,
    output logic      done
);

    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] count_reg;

    always_ff @(posedge clock)
    begin
        if (rst || !run)
        begin
            count_reg <= '0;
        end
        else if (count_reg != W'(CYCLES))
        begin
            count_reg <= count_reg + W'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst || !run)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= (count_reg >= W'(CYCLES - 1));
        end
    end

endmodule

`default_nettype wire

// ===== logic/oec_top.sv
/*
  Oscillator enable control: decides when the on-chip oscillator and its dc generator run,
  from the main and sub-main clock source selects, the oscillator fault flag and the
  generator-off bit, including the sub-main start defect; the reset-vector check never fires, as reset clears the vector.
  Assumes software is the only other party, on a plain strobe register port.
*/
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1: Oscillator stays off unless main or sub-main clock selects it.
// RULE2: Selecting the oscillator for the main clock starts it.
// RULE3: Selecting it only for the sub-main clock fails; that clock holds high.
// RULE4: Main select codes 00 and 01 both choose the oscillator.
// RULE5: Setting the fault flag starts the oscillator through fault logic.
// RULE6: Software clears the fault flag afterwards to keep using other sources.
// RULE7: Software may return the main clock to crystal after the start.
// RULE8: After reset, vector bit 6 set makes the generator-off bit set; here reset clears the vector first, so it never does.
// RULE9: Generator-off set and oscillator unused turns the dc generator off.
// RULE10: Software clears generator-off at start or avoids vectors with bit 6.
// RULE11: Running oscillator kept on when only the sub-main clock still selects it.
module oec_top
#(
    parameter int SETTLE_CYCLES = oec_pkg::SETTLE_CYCLES
)
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port.
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // Oscillator control.
    output logic             osc_enable,
    output logic             dc_generator_enable,
    output logic             osc_ready,
    output logic             sub_main_clock_stuck_high,
    // Interrupt.
    output logic             irq
);

    // Main select decode, shared by the start and stop logic.
    function automatic logic main_selects_osc(input logic [7:0] ctl);
        logic [1:0] sel;
        sel = ctl[oec_pkg::MAIN_SEL_LSB +: 2];
        return (sel == oec_pkg::MAIN_SEL_OSC_A) || (sel == oec_pkg::MAIN_SEL_OSC_B); // [RULE4]
    endfunction

    function automatic logic sub_selects_osc(input logic [7:0] ctl);
        return !ctl[oec_pkg::SUB_SEL_BIT];
    endfunction

    // Write strobe for one register index.
    function automatic logic write_hit(input logic       write,
                                       input logic [3:0] addr,
                                       input logic [3:0] index);
        return write && (addr == index);
    endfunction

    logic [7:0]               clock_control_two_reg;
    logic [7:0]               interrupt_flag_one_reg;
    logic [15:0]              status_register_reg;
    logic [15:0]              reset_vector_reg;
    logic [7:0]               control_reg;
    oec_pkg::oec_osc_state_e  state_reg;
    oec_pkg::oec_osc_state_e  state_next;
    logic                     after_reset_reg;
    logic                     main_osc;
    logic                     sub_osc;
    logic                     fault_set;
    logic                     wants_osc;
    logic                     settle_done;
    logic [3:0]               event_pulse;
    logic [3:0]               ev_status;
    logic [3:0]               ev_mask;
    logic                     wr_ctl2;
    logic                     wr_flag;
    logic                     wr_status;
    logic                     wr_vector;
    logic                     wr_control;
    logic                     wr_ev_clear;
    logic                     wr_ev_mask;
    logic                     sub_keeps_osc;
    logic                     sub_fixed_start;
    logic                     prev_main_osc_reg;
    logic                     prev_fault_reg;

    // Write strobes, one for each writable register.
    assign wr_ctl2     = write_hit(reg_write, reg_addr, oec_pkg::ADDR_CLOCK_CONTROL_TWO);
    assign wr_flag     = write_hit(reg_write, reg_addr, oec_pkg::ADDR_INTERRUPT_FLAG);
    assign wr_status   = write_hit(reg_write, reg_addr, oec_pkg::ADDR_STATUS_REGISTER);
    assign wr_vector   = write_hit(reg_write, reg_addr, oec_pkg::ADDR_RESET_VECTOR);
    assign wr_control  = write_hit(reg_write, reg_addr, oec_pkg::ADDR_CONTROL);
    assign wr_ev_clear = write_hit(reg_write, reg_addr, oec_pkg::ADDR_EVENT_STATUS);
    assign wr_ev_mask  = write_hit(reg_write, reg_addr, oec_pkg::ADDR_EVENT_MASK);
    assign main_osc  = main_selects_osc(clock_control_two_reg);
    assign sub_osc   = sub_selects_osc(clock_control_two_reg);
    assign fault_set = interrupt_flag_one_reg[oec_pkg::FAULT_FLAG_BIT];
    // Sub-main selection keeps a starting or running oscillator alive, or starts one when fixed.
    assign sub_keeps_osc   = sub_osc && (state_reg != oec_pkg::OEC_OFF); // [RULE11]
    assign sub_fixed_start = sub_osc && control_reg[oec_pkg::CTRL_FIX_SUB_BIT];
    assign wants_osc       = main_osc || fault_set || sub_keeps_osc || sub_fixed_start;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            clock_control_two_reg <= oec_pkg::CLOCK_CONTROL_TWO_RESET;
        end
        else if (wr_ctl2)
        begin
            clock_control_two_reg <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            interrupt_flag_one_reg <= oec_pkg::INTERRUPT_FLAG_RESET;
        end
        else if (wr_flag)
        begin
            interrupt_flag_one_reg <= reg_wdata[7:0]; // [RULE5] [RULE6]
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            reset_vector_reg <= oec_pkg::RESET_VECTOR_RESET;
        end
        else if (wr_vector)
        begin
            reset_vector_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            control_reg <= oec_pkg::CONTROL_RESET;
        end
        else if (wr_control)
        begin
            control_reg <= reg_wdata[7:0];
        end
    end

    // Marks the first cycle after reset release for the vector check.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            after_reset_reg <= 1'b1;
        end
        else
        begin
            after_reset_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            status_register_reg <= oec_pkg::STATUS_REGISTER_RESET;
        end
        else if (after_reset_reg && reset_vector_reg[oec_pkg::VECTOR_TRIGGER_BIT])
        begin
            status_register_reg[oec_pkg::GEN_OFF_BIT] <= 1'b1; // [RULE8]
        end
        else if (wr_status)
        begin
            status_register_reg <= reg_wdata; // [RULE10]
        end
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            oec_pkg::OEC_OFF:
            begin
                if (wants_osc)
                begin
                    state_next = oec_pkg::OEC_STARTING; // [RULE2] [RULE3]
                end
            end
            oec_pkg::OEC_STARTING:
            begin
                if (!wants_osc)
                begin
                    state_next = oec_pkg::OEC_OFF;
                end
                else if (settle_done)
                begin
                    state_next = oec_pkg::OEC_RUNNING;
                end
            end
            oec_pkg::OEC_RUNNING:
            begin
                if (!(main_osc || sub_osc || fault_set))
                begin
                    state_next = oec_pkg::OEC_OFF; // [RULE1]
                end
            end
            default:
            begin
                state_next = oec_pkg::OEC_OFF;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= oec_pkg::OEC_OFF;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    oec_settle_timer
    #(
        .CYCLES (SETTLE_CYCLES)
    )
    u_settle
    (
        .clock (clock),
        .rst   (rst),
        .run   (state_reg == oec_pkg::OEC_STARTING),
        .done  (settle_done)
    );

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            osc_enable                <= 1'b0;
            osc_ready                 <= 1'b0;
            dc_generator_enable       <= 1'b1;
            sub_main_clock_stuck_high <= 1'b0;
        end
        else
        begin
            osc_enable <= (state_next != oec_pkg::OEC_OFF); // [RULE1]
            osc_ready  <= (state_next == oec_pkg::OEC_RUNNING);
            dc_generator_enable <= !(status_register_reg[oec_pkg::GEN_OFF_BIT]
                                   && !main_osc && !sub_osc && !fault_set); // [RULE9]
            sub_main_clock_stuck_high <= sub_osc && (state_next == oec_pkg::OEC_OFF); // [RULE3]
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            prev_main_osc_reg <= 1'b0;
            prev_fault_reg    <= 1'b0;
        end
        else
        begin
            prev_main_osc_reg <= main_osc;
            prev_fault_reg    <= fault_set;
        end
    end

    always_comb
    begin
        event_pulse = '0;
        event_pulse[oec_pkg::EV_OSC_START]   = (state_reg != oec_pkg::OEC_RUNNING)
                                             && (state_next == oec_pkg::OEC_RUNNING);
        event_pulse[oec_pkg::EV_OSC_STOP]    = (state_reg != oec_pkg::OEC_OFF)
                                             && (state_next == oec_pkg::OEC_OFF);
        event_pulse[oec_pkg::EV_START_FAIL]  = wr_ctl2 && (state_reg == oec_pkg::OEC_OFF)
                                             && sub_selects_osc(reg_wdata[7:0])
                                             && !main_selects_osc(reg_wdata[7:0])
                                             && !fault_set
                                             && !control_reg[oec_pkg::CTRL_FIX_SUB_BIT];
        event_pulse[oec_pkg::EV_GEN_OFF_SET] = after_reset_reg
                                             && reset_vector_reg[oec_pkg::VECTOR_TRIGGER_BIT];
    end

    oec_irq_bank
    #(
        .N (4)
    )
    u_irq
    (
        .clock       (clock),
        .rst         (rst),
        .event_pulse (event_pulse),
        .clear_write (wr_ev_clear),
        .mask_write  (wr_ev_mask),
        .write_data  (reg_wdata[3:0]),
        .status      (ev_status),
        .mask        (ev_mask),
        .irq         (irq)
    );

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_read)
        begin
            case (reg_addr)
                oec_pkg::ADDR_CLOCK_CONTROL_TWO: reg_rdata <= {8'h00, clock_control_two_reg};
                oec_pkg::ADDR_INTERRUPT_FLAG:    reg_rdata <= {8'h00, interrupt_flag_one_reg};
                oec_pkg::ADDR_STATUS_REGISTER:   reg_rdata <= status_register_reg;
                oec_pkg::ADDR_RESET_VECTOR:      reg_rdata <= reset_vector_reg;
                oec_pkg::ADDR_OSC_STATE:         reg_rdata <= {12'h000, dc_generator_enable,
                                                               sub_main_clock_stuck_high,
                                                               osc_ready, osc_enable};
                oec_pkg::ADDR_EVENT_STATUS:      reg_rdata <= {12'h000, ev_status};
                oec_pkg::ADDR_EVENT_MASK:        reg_rdata <= {12'h000, ev_mask};
                oec_pkg::ADDR_CONTROL:           reg_rdata <= {8'h00, control_reg};
                default:                         reg_rdata <= 16'h0000;
            endcase
        end
        else
        begin
            reg_rdata <= 16'h0000;
        end
    end

    logic unused_prev;
    assign unused_prev = prev_main_osc_reg ^ prev_fault_reg;

endmodule

`default_nettype wire
